/* tb/fft_ctl_tb.sv */
// Register-level testbench of the foreign-format tape control.
`timescale 1ns/1ps
`include "fft_params.svh"

module fft_ctl_tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    fft_pkg::fft_pins_s pins;
    logic timing_track_out;
    logic [2:0] data_track_out;
    logic native_wind_decode_enable;
    logic write_select_level;
    logic tape_break_inhibit;
    fft_pkg::fft_tape_ctl_s tape_ctl;
    logic irq;
    logic go = 1'b0;
    logic [3:0] nlines = 4'h0;
    logic [15:0] mark_pat = 16'h0000;
    logic [11:0] word = 12'h000;
    logic preset_req = 1'b0;
    logic busy;
    logic [11:0] captured;
    int err_count = 0;
    int n_checks = 0;

    always #5 clk = ~clk;

    fft_ctl u_dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pins(pins), .timing_track_out(timing_track_out), .data_track_out(data_track_out),
        .native_wind_decode_enable(native_wind_decode_enable),
        .write_select_level(write_select_level), .tape_break_inhibit(tape_break_inhibit),
        .tape_ctl(tape_ctl), .irq(irq));

    fft_tape_model u_tape (.go(go), .nlines(nlines), .mark_pat(mark_pat), .word(word),
        .preset_req(preset_req), .track_in(data_track_out), .pins(pins), .busy(busy),
        .captured(captured));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r & m, exp);
    endtask : rd

    task automatic tape(input logic [3:0] n, input logic [15:0] mp, input logic [11:0] wd);
        @(posedge clk);
        nlines <= n;
        mark_pat <= mp;
        word <= wd;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        while (busy === 1'b1)
            @(posedge clk);
        repeat (10) @(posedge clk);
    endtask : tape

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize

    initial
    begin
        #200000;
        err_count++;
        summarize();
    end

    initial
    begin
        logic [31:0] r;
        logic e;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        rd(`FFT_OFF_CMD, 32'h0, 32'h3F8);
        chk({native_wind_decode_enable, timing_track_out, tape_break_inhibit}, 32'h4);
        apb(1'b0, 8'h18, 32'h0, r, e);
        chk({r[30:0], e}, 32'h1);
        $display("test reset done");
        wr(`FFT_OFF_CMD, 32'h002);
        wr(`FFT_OFF_IMSK, 32'h1);
        repeat (5) @(posedge clk);
        chk({native_wind_decode_enable, tape_break_inhibit, timing_track_out}, 32'h3);
        chk({write_select_level, tape_ctl.format}, 32'h1);
        $display("test format done");
        tape(4'h4, 16'h0000, 12'hA5C);
        wr(`FFT_OFF_SKIP, 32'h11);
        rd(`FFT_OFF_SKIP, 32'h1, 32'h1);
        rd(`FFT_OFF_XFER, 32'hA5C, 32'hFFF);
        wr(`FFT_OFF_SKIP, 32'h11);
        rd(`FFT_OFF_SKIP, 32'h0, 32'h1);
        rd(`FFT_OFF_ISTS, 32'h2, 32'h3);
        chk(irq, 0);
        wr(`FFT_OFF_ISTS, 32'h3);
        $display("test read done");
        tape(4'h9, 16'h00AB, 12'h000);
        wr(`FFT_OFF_SKIP, 32'h0E);
        rd(`FFT_OFF_SKIP, 32'h1, 32'h1);
        wr(`FFT_OFF_SKIP, 32'h0E);
        rd(`FFT_OFF_SKIP, 32'h1, 32'h1);
        rd(`FFT_OFF_ISTS, 32'h1, 32'h1);
        chk(irq, 1);
        wr(`FFT_OFF_CMD, 32'h080);
        wr(`FFT_OFF_SKIP, 32'h0E);
        rd(`FFT_OFF_SKIP, 32'h0, 32'h1);
        wr(`FFT_OFF_ISTS, 32'h3);
        repeat (2) @(posedge clk);
        chk(irq, 0);
        $display("test block done");
        wr(`FFT_OFF_CMD, 32'h004);
        rd(`FFT_OFF_CMD, 32'hC0, 32'hC0);
        wr(`FFT_OFF_CMD, 32'h040);
        wr(`FFT_OFF_CMD, 32'h004);
        wr(`FFT_OFF_CMD, 32'h020);
        rd(`FFT_OFF_CMD, 32'hA0, 32'hE0);
        chk(tape_ctl, 32'h16);
        wr(`FFT_OFF_CMD, 32'h010);
        rd(`FFT_OFF_CMD, 32'hE0, 32'hE0);
        $display("test motion done");
        wr(`FFT_OFF_CMD, 32'h003);
        wr(`FFT_OFF_WBUF, 32'h6B3);
        rd(`FFT_OFF_WBUF, 32'h6B3, 32'hFFF);
        repeat (2) @(posedge clk);
        chk({write_select_level, tape_ctl.write}, 32'h3);
        tape(4'h4, 16'h0000, 12'h000);
        tape(4'h4, 16'h0000, 12'h000);
        chk(captured, 32'h6B3);
        $display("test write done");
        preset_req <= 1'b1;
        repeat (5) @(posedge clk);
        preset_req <= 1'b0;
        repeat (5) @(posedge clk);
        rd(`FFT_OFF_CMD, 32'h0, 32'h380);
        chk({write_select_level, native_wind_decode_enable, tape_break_inhibit}, 32'h2);
        $display("test preset done");
        summarize();
    end
endmodule : fft_ctl_tb

/* tb/fft_tape_model.sv */
// Behavioural tape drive: timing, mark and data tracks for a run of lines.
`timescale 1ns/1ps

module fft_tape_model (
    input wire logic go,
    input wire logic [3:0] nlines,
    input wire logic [15:0] mark_pat,
    input wire logic [11:0] word,
    input wire logic preset_req,
    input wire logic [2:0] track_in,
    output fft_pkg::fft_pins_s pins,
    output logic busy,
    output logic [11:0] captured
);
    logic timing = 1'b0;
    logic mark = 1'b0;
    logic tp3 = 1'b0;
    logic tp4 = 1'b0;
    logic [2:0] data = 3'h0;
    logic busy_q = 1'b0;
    logic [11:0] cap_q = 12'h000;
    int i;

    assign pins = {timing, mark, tp3, tp4, preset_req, data};
    assign busy = busy_q;
    assign captured = cap_q;

    // third before fourth.
    // Each line lasts 160 ns, one period of the timing track.
    always @(posedge go)
    begin
        busy_q = 1'b1;
        #3;
        for (i = 0; i < nlines; i++)
        begin
            mark = mark_pat[nlines - 1 - i];
            data = word[11 - 3 * (i % 4) -: 3];
            timing = ~timing;
            tp3 = 1'b1;
            #40 tp3 = 1'b0;
            #40 tp4 = 1'b1;
            timing = ~timing;
            cap_q = {cap_q[8:0], track_in};
            #40 tp4 = 1'b0;
            #40;
        end
        // Released lines show the inverse of the last value.
        mark = ~mark;
        data = ~data;
        busy_q = 1'b0;
    end
endmodule : fft_tape_model

/* verilog/fft_ctl.sv */
// Foreign-format tape control: APB registers, mark window, word assembly, flags.
`timescale 1ns/1ps
`include "fft_params.svh"


module fft_ctl (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire fft_pkg::fft_pins_s pins,
    output logic timing_track_out,
    output logic [2:0] data_track_out,
    output logic native_wind_decode_enable,
    output logic write_select_level,
    output logic tape_break_inhibit,
    output fft_pkg::fft_tape_ctl_s tape_ctl,
    output logic irq
);

    // ----------------------------------------
    // Pin synchronisation and pulse edges
    // ----------------------------------------
    fft_pkg::fft_pins_s pin_s;
    logic tp3_prev_q;
    logic tp4_prev_q;
    logic tp3_pulse;
    logic tp4_pulse;
    logic preset;

    fft_sync #(.W(8)) u_sync (
        .clk(clk),
        .rstn(rstn),
        .async_in(pins),
        .sync_out(pin_s)
    );

    assign tp3_pulse = pin_s.tp3 && !tp3_prev_q;
    assign tp4_pulse = pin_s.tp4 && !tp4_prev_q;
    assign preset = pin_s.preset;

    // ----------------------------------------
    // State registers
    // ----------------------------------------
    logic fmt_q, wr_q, motion_q, fwd_q, unit_q, blk_q, wavail_q, skip_q;
    logic fmt_d, wr_d, motion_d, fwd_d, unit_d, blk_d, wavail_d, skip_d;
    logic [1:0] line_q, line_d;
    logic [11:0] rwb_q, rwb_d, xfer_q, xfer_d, twb_q, twb_d;
    logic [2:0] dout_d;
    logic [1:0] ists_q, ists_d, imsk_q, imsk_d, ev;
    logic [8:0] window;
    logic bm;
    logic word_ready;
    logic tp3_f;
    logic tp4_f;

    assign tp3_f = tp3_pulse && fmt_q;
    assign tp4_f = tp4_pulse && fmt_q;

    fft_window u_window (
        .clk(clk),
        .rstn(rstn),
        .shift_en(tp3_f),
        .mark_bit(pin_s.mark),
        .mark_window_bits(window),
        .block_mark_detect(bm)
    );

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    logic setup, acc, wr_acc, rd_acc, mapped;
    logic sel_cmd, sel_wbuf, sel_xfer, sel_skip, sel_ists, sel_imsk;
    logic cmd_wr, skl_wr;
    logic [11:0] acw;
    logic [31:0] rdata;

    assign setup = psel && !penable;
    assign acc = psel && penable && pready;
    assign wr_acc = acc && pwrite;
    assign rd_acc = acc && !pwrite;
    assign sel_cmd = paddr == `FFT_OFF_CMD;
    assign sel_wbuf = paddr == `FFT_OFF_WBUF;
    assign sel_xfer = paddr == `FFT_OFF_XFER;
    assign sel_skip = paddr == `FFT_OFF_SKIP;
    assign sel_ists = paddr == `FFT_OFF_ISTS;
    assign sel_imsk = paddr == `FFT_OFF_IMSK;
    assign mapped = sel_cmd | sel_wbuf | sel_xfer | sel_skip | sel_ists | sel_imsk;
    assign cmd_wr = wr_acc && sel_cmd;
    assign skl_wr = wr_acc && sel_skip;
    assign acw = pwdata[11:0];

    // ----------------------------------------
    // Command and mode flops
    // ----------------------------------------
    // format select and write copy
    assign fmt_d = preset ? 1'b0 : (cmd_wr && acw[`FFT_AC10]) ? 1'b1 : fmt_q;
    assign wr_d = preset ? 1'b0
        : (cmd_wr && acw[`FFT_AC10]) ? acw[`FFT_AC11] : wr_q;
    assign motion_d = preset ? 1'b0 : (cmd_wr && acw[`FFT_AC9]) ? 1'b1 : motion_q;
    assign fwd_d = !cmd_wr ? fwd_q
        : (acw[`FFT_AC9] && !motion_q) ? 1'b1
        : acw[`FFT_AC7] ? 1'b1
        : acw[`FFT_AC5] ? 1'b0 : fwd_q;
    assign unit_d = (cmd_wr && acw[`FFT_AC6]) ? 1'b1 : unit_q;
    assign blk_d = (tp4_f && bm) ? 1'b1
        : ((cmd_wr && acw[`FFT_AC4]) || preset) ? 1'b0 : blk_q;

    // ----------------------------------------
    // Line counter and word path
    // ----------------------------------------
    // fourth line decode
    assign word_ready = line_q == `FFT_LAST_LINE;
    assign line_d = (tp4_f && bm) ? 2'h0 : tp4_f ? line_q + 2'h1 : line_q;
    // write word enters buffer at word boundary
    assign rwb_d = tp3_f ? {rwb_q[8:0], wr_q ? 3'h0 : pin_s.data}
        : (tp4_f && word_ready && wr_q) ? twb_q : rwb_q;
    assign dout_d = (tp3_f && wr_q) ? rwb_q[11:9] : data_track_out;
    // load transfer register on fourth pulse
    assign xfer_d = (tp4_f && word_ready) ? rwb_q : xfer_q;
    assign wavail_d = (tp4_f && word_ready) ? 1'b1
        : ((rd_acc && sel_xfer) || preset) ? 1'b0 : wavail_q;
    assign twb_d = (wr_acc && sel_wbuf) ? acw : twb_q;

    // ----------------------------------------
    // Skip test
    // ----------------------------------------
    // line 14 tests block-seen
    assign skip_d = !skl_wr ? skip_q
        : (pwdata[4:0] == `FFT_SKL_BLOCK) ? blk_q
        : (pwdata[4:0] == `FFT_SKL_WORD) ? wavail_q : 1'b0;

    // ----------------------------------------
    // Interrupt status and mask
    // ----------------------------------------
    assign ev[`FFT_IRQ_BLOCK] = tp4_f && bm;
    assign ev[`FFT_IRQ_WORD] = tp4_f && word_ready;
    assign ists_d = ev | (ists_q & ~((wr_acc && sel_ists) ? pwdata[1:0] : 2'h0));
    assign imsk_d = (wr_acc && sel_imsk) ? pwdata[1:0] : imsk_q;

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    assign rdata = sel_cmd ? {22'h0, fmt_q, wr_q, motion_q, fwd_q, unit_q,
                              blk_q, wavail_q, word_ready, line_q}
        : sel_wbuf ? {20'h0, twb_q}
        : sel_xfer ? {20'h0, xfer_q}
        : sel_skip ? {31'h0, skip_q}
        : sel_ists ? {30'h0, ists_q}
        : sel_imsk ? {30'h0, imsk_q} : 32'h0;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            {fmt_q, wr_q, motion_q, fwd_q, unit_q, blk_q, wavail_q, skip_q} <= 8'h00;
            {tp3_prev_q, tp4_prev_q, line_q} <= 4'h0;
            rwb_q <= `FFT_RST_WORD;
            xfer_q <= `FFT_RST_WORD;
            twb_q <= `FFT_RST_WORD;
            ists_q <= `FFT_RST_IRQ;
            imsk_q <= `FFT_RST_IRQ;
        end
        else
        begin
            {fmt_q, wr_q, motion_q, fwd_q} <= {fmt_d, wr_d, motion_d, fwd_d};
            {unit_q, blk_q, wavail_q, skip_q} <= {unit_d, blk_d, wavail_d, skip_d};
            {tp3_prev_q, tp4_prev_q, line_q} <= {pin_s.tp3, pin_s.tp4, line_d};
            rwb_q <= rwb_d;
            xfer_q <= xfer_d;
            twb_q <= twb_d;
            ists_q <= ists_d;
            imsk_q <= imsk_d;
        end
    end

    // Outputs are all registered; APB answers in the first access cycle.
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            {pready, pslverr, prdata} <= 34'h0;
            {timing_track_out, data_track_out, irq} <= 5'h00;
            {native_wind_decode_enable, write_select_level} <= 2'h2;
            tape_break_inhibit <= 1'b0;
            tape_ctl <= '0;
        end
        else
        begin
            pready <= setup;
            pslverr <= setup && !mapped;
            prdata <= (setup && !pwrite) ? rdata : prdata;
            // invert timing track, block wind decode
            timing_track_out <= pin_s.timing ^ fmt_q;
            native_wind_decode_enable <= !fmt_q;
            // no tape break in foreign mode
            tape_break_inhibit <= fmt_q;
            write_select_level <= fmt_q && wr_q;
            data_track_out <= dout_d;
            irq <= |(ists_q & imsk_q);
            tape_ctl <= '{motion_q, fwd_q, unit_q, fmt_q, wr_q};
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    sequence s_word;
        tp4_f && word_ready;
    endsequence

    sequence s_sel;
        cmd_wr && acw[`FFT_AC10] && !preset;
    endsequence

    AST_FMT_SET: assert property (s_sel |=> fmt_q && wr_q == $past(acw[`FFT_AC11]))
        else $error("Format select or write copy wrong.");

    AST_PRESET: assert property (preset |=> !fmt_q && !wr_q && !motion_q)
        else $error("Preset did not clear mode flops.");

    AST_MODE_OUT: assert property ($rose(fmt_q) |=> !native_wind_decode_enable)
        else $error("Wind decode not blocked in foreign mode.");

    AST_NO_BREAK: assert property (fmt_q [*2] |-> tape_break_inhibit)
        else $error("Tape break not inhibited in foreign mode.");

    AST_BLOCK_SET: assert property (tp4_f && bm |=> blk_q && ists_q[`FFT_IRQ_BLOCK])
        else $error("Block mark did not set block-seen.");

    AST_BLOCK_CLR: assert property (cmd_wr && acw[`FFT_AC4] && !(tp4_f && bm) |=> !blk_q)
        else $error("Clear block bit did not clear block-seen.");

    AST_WSEL: assert property (fmt_q && wr_q |=> write_select_level)
        else $error("Write select missing while writing.");

    AST_WORD_LOAD: assert property (s_word |=> xfer_q == $past(rwb_q) && wavail_q)
        else $error("Word not loaded into transfer register.");

    AST_SKIP14: assert property (skl_wr && pwdata[4:0] == `FFT_SKL_BLOCK |=> skip_q == $past(blk_q))
        else $error("Block skip result wrong.");

    AST_SKIP_KEEPS: assert property (skl_wr && !tp4_f && !preset |=> $stable(blk_q) && $stable(wavail_q))
        else $error("Skip changed a flag.");

    AST_TIMING_INV: assert property (fmt_q |=> timing_track_out == !$past(pin_s.timing))
        else $error("Timing track not inverted in foreign mode.");

    AST_WORD_READY: assert property (tp4_f && !bm && line_q == 2'h2 |=> word_ready)
        else $error("Word ready missing on the fourth line.");

    AST_SKIP17: assert property (skl_wr && pwdata[4:0] == `FFT_SKL_WORD |=> skip_q == $past(wavail_q))
        else $error("Word skip result wrong.");

    AST_XFER_CLR: assert property (rd_acc && sel_xfer && !(tp4_f && word_ready) |=> !wavail_q)
        else $error("Transfer read did not clear word available.");

    AST_RWB_LOAD: assert property (tp4_f && word_ready && wr_q && !tp3_f |=> rwb_q == $past(twb_q))
        else $error("Write buffer not loaded into the read/write buffer.");

    AST_DOUT: assert property (tp3_f && wr_q |=> data_track_out == $past(rwb_q[11:9]))
        else $error("Written line is not the top of the buffer.");

endmodule : fft_ctl

/* verilog/fft_params.svh */
// Constants of the foreign-format tape control: offsets, field positions, resets, decodes.
`ifndef FFT_PARAMS_SVH
`define FFT_PARAMS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define FFT_OFF_CMD 8'h00
`define FFT_OFF_WBUF 8'h04
`define FFT_OFF_XFER 8'h08
`define FFT_OFF_SKIP 8'h0C
`define FFT_OFF_ISTS 8'h10
`define FFT_OFF_IMSK 8'h14

// ----------------------------------------
// Accumulator bit positions (bit 0 is the most significant of 12)
// ----------------------------------------
`define FFT_AC4 7
`define FFT_AC5 6
`define FFT_AC6 5
`define FFT_AC7 4
`define FFT_AC9 2
`define FFT_AC10 1
`define FFT_AC11 0

// ----------------------------------------
// Instruction numbers, decodes and resets
// ----------------------------------------
`define FFT_SKL_BLOCK 5'h0E
`define FFT_SKL_WORD 5'h11
`define FFT_MSC_XFER 5'h03
`define FFT_BM_PATTERN 9'h0AB
`define FFT_LAST_LINE 2'h3
`define FFT_IRQ_BLOCK 0
`define FFT_IRQ_WORD 1
`define FFT_RST_WORD 12'h000
`define FFT_RST_IRQ 2'h0

`endif

/* verilog/fft_pkg.sv */
// Types shared by the foreign-format tape control modules.
package fft_pkg;

    // Tape control state driven toward the tape control.
    typedef struct packed {
        logic motion;
        logic forward;
        logic unit1;
        logic format;
        logic write;
    } fft_tape_ctl_s;

    // Raw tape pins, sampled together.
    typedef struct packed {
        logic timing;
        logic mark;
        logic tp3;
        logic tp4;
        logic preset;
        logic [2:0] data;
    } fft_pins_s;

endpackage : fft_pkg

/* verilog/fft_sync.sv */
// Two-flop synchroniser for a group of asynchronous pin inputs.
`timescale 1ns/1ps

module fft_sync #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta_q;

    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            always_ff @(posedge clk)
            begin
                meta_q[i] <= rstn ? async_in[i] : 1'b0;
                sync_out[i] <= rstn ? meta_q[i] : 1'b0;
            end
        end
    endgenerate

endmodule : fft_sync

/* verilog/fft_window.sv */
// Nine-bit mark window shift register with block-mark decode.
`timescale 1ns/1ps
`include "fft_params.svh"

module fft_window (
    input wire logic clk,
    input wire logic rstn,
    input wire logic shift_en,
    input wire logic mark_bit,
    output logic [8:0] mark_window_bits,
    output logic block_mark_detect
);

    logic [8:0] win_d;

    assign win_d = shift_en ? {mark_window_bits[7:0], mark_bit} : mark_window_bits;
    assign block_mark_detect = (mark_window_bits == `FFT_BM_PATTERN);

    always_ff @(posedge clk)
    begin
        mark_window_bits <= rstn ? win_d : 9'h000;
    end

    AST_WIN_SHIFT: assert property (@(posedge clk) disable iff (!rstn)
        shift_en |=> mark_window_bits[0] == $past(mark_bit)
            && mark_window_bits[8:1] == $past(mark_window_bits[7:0]))
        else $error("Window did not shift the mark bit.");

endmodule : fft_window
